/* File: hdl/codec_control_host.sv */
// Host end: issues 3-wire or I2C register writes and reads on request.
// Assumes the codec end is on the same clock; start is taken only while busy is low.
`timescale 1ns/1ps
`default_nettype none
module codec_control_host (
    input wire logic clock, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic useI2c, // High selects the I2C link.
    input wire logic addressSelect, // Slave address low bit.
    input wire logic start, // Pulse: begin a transfer.
    input wire logic write, // High write, low read.
    input wire logic [6:0] regAddr, // Register address.
    input wire logic [7:0] wrData, // Write data.
    codec_ctrl_if.host link, // Link pins.
    output logic busy, // High while a transfer runs.
    output logic done, // One-cycle pulse at the end.
    output logic [7:0] rdData, // Read result.
    output logic nack // Last I2C transfer saw no acknowledge.
);
    import codec_ctrl_pkg::*;

    typedef enum {H_IDLE, H_RUN, H_END} host_state_t;

    host_state_t state;
    logic [7:0] tick;
    logic [7:0] phase;
    logic [15:0] frame;
    logic [35:0] seq;
    logic opRead, opI2c;

    wire logic [7:0] halfLen = opI2c ? 8'(I2C_HALF_CYC) : 8'(WIRE3_HALF_CYC);
    wire logic tickDone = (tick == 8'(halfLen - 8'd1));

    // 3-wire: 32 half periods of a 16-bit frame. I2C: a 4-phase bit slot.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= H_IDLE;
            tick <= 8'd0;
            phase <= 8'd0;
            frame <= 16'h0000;
            seq <= 36'h0;
            opRead <= 1'b0;
            opI2c <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            rdData <= 8'h00;
            nack <= 1'b0;
            link.chip_select_n <= 1'b1;
            link.control_serial_clock <= 1'b1;
            link.hostDataOut <= 1'b1;
            link.hostDataOe <= 1'b0;
            link.sclHostOe <= 1'b0;
            link.sdaHostOe <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            unique case (state)
                H_IDLE:
                begin
                    if (start)
                    begin
                        state <= H_RUN;
                        busy <= 1'b1;
                        opRead <= ~write;
                        opI2c <= useI2c;
                        tick <= 8'd0;
                        phase <= 8'd0;
                        nack <= 1'b0;
                        frame <= {write, regAddr, wrData};
                        // I2C bytes with their acknowledge slots: address+W, register, data or address+R.
                        seq <= {SLAVE_ADDR_HI, addressSelect, 1'b0, 1'b1, 2'b00, regAddr[5:0], 1'b1,
                                write ? wrData : {SLAVE_ADDR_HI, addressSelect, 1'b1}, 1'b1, 8'hFF, 1'b1};
                        link.chip_select_n <= useI2c;
                    end
                end
                H_RUN:
                begin
                    tick <= tickDone ? 8'd0 : 8'(tick + 8'd1);
                    if (tickDone && !opI2c)
                    begin
                        phase <= 8'(phase + 8'd1);
                        link.control_serial_clock <= phase[0];
                        if (!phase[0])
                        begin
                            link.hostDataOut <= frame[15];
                            link.hostDataOe <= !(opRead && phase >= 8'd16);
                            frame <= {frame[14:0], 1'b0};
                        end
                        else if (opRead && phase >= 8'd17)
                        begin
                            rdData <= {rdData[6:0], link.control_data_io};
                        end
                        if (phase == 8'd31)
                        begin
                            state <= H_END;
                        end
                    end
                    else if (tickDone)
                    begin
                        phase <= 8'(phase + 8'd1);
                        if (phase[1:0] == 2'd0)
                        begin
                            // Start before byte 0; a read's repeated start takes a slot of its own.
                            if (phase == 8'd0)
                            begin
                                link.sdaHostOe <= 1'b1;
                            end
                            else
                            begin
                                link.sclHostOe <= 1'b1;
                            end
                        end
                        else if (phase[1:0] == 2'd1)
                        begin
                            link.sclHostOe <= 1'b1;
                            if (opRead && phase == 8'd73)
                            begin
                                // The device holds its acknowledge until the clock fall of the previous phase, so the line is freed here.
                                link.sdaHostOe <= 1'b0;
                            end
                            else
                            begin
                                link.sdaHostOe <= ~seq[35];
                                seq <= {seq[34:0], 1'b1};
                            end
                        end
                        else if (phase[1:0] == 2'd2)
                        begin
                            link.sclHostOe <= 1'b0;
                            if (phase >= 8'd114 && phase < 8'd146)
                            begin
                                rdData <= {rdData[6:0], link.sda};
                            end
                            if ((phase == 8'd34 || phase == 8'd70 || phase == (opRead ? 8'd110 : 8'd106)) && link.sda)
                            begin
                                nack <= 1'b1;
                            end
                        end
                        else if (opRead && phase == 8'd75)
                        begin
                            link.sdaHostOe <= 1'b1;
                        end
                        if ((!opRead && phase == 8'd108) || phase == 8'd148)
                        begin
                            link.sclHostOe <= 1'b1;
                            link.sdaHostOe <= 1'b1;
                            state <= H_END;
                            phase <= 8'd0;
                        end
                    end
                end
                H_END:
                begin
                    tick <= tickDone ? 8'd0 : 8'(tick + 8'd1);
                    if (tickDone)
                    begin
                        link.sclHostOe <= 1'b0;
                        link.sdaHostOe <= link.sclHostOe;
                        link.chip_select_n <= 1'b1;
                        link.hostDataOe <= 1'b0;
                        if (!link.sclHostOe)
                        begin
                            state <= H_IDLE;
                            busy <= 1'b0;
                            done <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end
endmodule : codec_control_host
`default_nettype wire

/* File: hdl/codec_control_port.sv */
// Device end of the codec control port: 3-wire slave, I2C slave and the register file behind them.
// Assumes link pins are synchronous to clock and the host keeps its own speed and framing limits.
// Notes on behaviour
// - 3-wire frame: direction, 7 address, 8 data
// - 3-wire bits sampled on serial clock rise
// - 3-wire write commits on chip select rise
// - Direction 1 writes, 0 reads
// - Drive read data from eighth clock fall
// - Data line released except during read
// - Host keeps serial clock at most 5MHz
// - Power-down low resets all registers
// - 3-wire readable: 00-11, 24-2B, 30-31
// - Interface-select high picks I2C
// - I2C slave up to 400kHz
// - Slave address 001001 plus select pin
// - Acknowledge only own address; bit sets direction
// - Host sends register address second, top zero; host and device here carry only its low six bits, top two zero
// - Acknowledge every received byte
// - Write auto-increment, wrap after 4F
// - Acked read byte advances, wrap after 4F
// - I2C readable excludes 0D
// - Current read uses last address plus one
// - No-ack then stop ends transmission
// - Random read: dummy write then restart
`timescale 1ns/1ps
`default_nettype none
module codec_control_port (
    input wire logic clock, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic power_down_pin, // Register reset while low.
    input wire logic i2cSelect, // High selects the I2C link.
    input wire logic address_select_pin, // Lowest I2C slave address bit.
    codec_ctrl_if.device link, // Link pins.
    input wire logic [6:0] peekAddr, // User-side register read address.
    output logic [7:0] peekData, // Registered register contents.
    output logic writeStrobe, // One-cycle pulse on each register write.
    output logic [6:0] writeAddr // Address of the last write.
);
    import codec_ctrl_pkg::*;

    typedef enum {I_IDLE, I_ADDR, I_REG, I_WDATA, I_RDATA, I_MACK, I_ACK} i2c_state_t;

    logic [7:0] regs [NUM_REGS];
    logic csPrev, sckPrev, sclPrev, sdaPrev;
    logic [4:0] bitCount;
    logic [15:0] shift3;
    logic [7:0] readOut3;
    i2c_state_t state, ackNext;
    logic [3:0] ibit;
    logic [7:0] ishift, txByte;
    logic [6:0] counter;
    logic readMode;

    wire logic w3Active = ~i2cSelect;
    wire logic sckRise = w3Active & ~link.chip_select_n & link.control_serial_clock & ~sckPrev;
    wire logic sckFall = w3Active & ~link.chip_select_n & ~link.control_serial_clock & sckPrev;
    wire logic csRise = w3Active & link.chip_select_n & ~csPrev;
    wire logic sclRise = i2cSelect & link.scl & ~sclPrev;
    wire logic sclFall = i2cSelect & ~link.scl & sclPrev;
    wire logic startCond = i2cSelect & link.scl & sclPrev & sdaPrev & ~link.sda;
    wire logic stopCond = i2cSelect & link.scl & sclPrev & ~sdaPrev & link.sda;
    wire logic [7:0] rxByte = {ishift[6:0], link.sda};
    wire logic addrMatch = rxByte[7:1] == {SLAVE_ADDR_HI, address_select_pin};
    wire logic [6:0] w3Addr = shift3[14:8];
    wire logic w3Write = shift3[15] & (bitCount == 5'd16);
    wire logic i2cWrite = (state == I_WDATA) & sclRise & (ibit == 4'd7);
    wire logic [7:0] i2cRead = i2cReadable(counter) ? regs[counter] : 8'h00;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            csPrev <= 1'b1;
            sckPrev <= 1'b0;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end
        else
        begin
            csPrev <= link.chip_select_n;
            sckPrev <= link.control_serial_clock;
            sclPrev <= link.scl;
            sdaPrev <= link.sda;
        end
    end

    // Register file; power-down wins over any write in progress.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                regs[i] <= RESET_VALUE;
            end
            writeStrobe <= 1'b0;
            writeAddr <= 7'h00;
            peekData <= 8'h00;
        end
        else if (!power_down_pin)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                regs[i] <= RESET_VALUE;
            end
            writeStrobe <= 1'b0;
            peekData <= 8'h00;
        end
        else
        begin
            writeStrobe <= (csRise & w3Write) | i2cWrite;
            peekData <= regs[peekAddr];
            if (csRise && w3Write)
            begin
                regs[w3Addr] <= shift3[7:0];
                writeAddr <= w3Addr;
            end
            else if (i2cWrite)
            begin
                regs[counter] <= rxByte;
                writeAddr <= counter;
            end
        end
    end

    // 3-wire slave: read data is driven from the fall of the eighth clock until chip select rises.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            bitCount <= 5'd0;
            shift3 <= 16'h0000;
            readOut3 <= 8'h00;
            link.devDataOe <= 1'b0;
            link.devDataOut <= 1'b1;
        end
        else if (!w3Active || link.chip_select_n)
        begin
            bitCount <= 5'd0;
            link.devDataOe <= 1'b0;
        end
        else
        begin
            if (sckRise)
            begin
                shift3 <= {shift3[14:0], link.control_data_io};
                bitCount <= (bitCount == 5'd16) ? bitCount : 5'(bitCount + 5'd1);
            end
            if (sckFall && bitCount == 5'd8 && !shift3[7])
            begin
                readOut3 <= wire3Readable(shift3[6:0]) ? regs[shift3[6:0]] : 8'h00;
                link.devDataOut <= wire3Readable(shift3[6:0]) ? regs[shift3[6:0]][7] : 1'b0;
                link.devDataOe <= 1'b1;
            end
            else if (sckFall && link.devDataOe)
            begin
                readOut3 <= {readOut3[6:0], 1'b0};
                link.devDataOut <= readOut3[6];
            end
        end
    end

    // I2C slave; sda changes only while scl is low.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= I_IDLE;
            ackNext <= I_IDLE;
            ibit <= 4'd0;
            ishift <= 8'h00;
            txByte <= 8'h00;
            counter <= 7'h00;
            readMode <= 1'b0;
            link.sdaDevOe <= 1'b0;
        end
        else if (!power_down_pin || !i2cSelect || stopCond)
        begin
            state <= I_IDLE;
            link.sdaDevOe <= 1'b0;
            if (!power_down_pin)
            begin
                counter <= 7'h00;
            end
        end
        else if (startCond)
        begin
            state <= I_ADDR;
            ibit <= 4'd0;
            link.sdaDevOe <= 1'b0;
        end
        else
        begin
            if (sclRise && (state == I_ADDR || state == I_REG || state == I_WDATA))
            begin
                ishift <= rxByte;
                ibit <= 4'(ibit + 4'd1);
                if (ibit == 4'd7)
                begin
                    ibit <= 4'd0;
                    if (state == I_ADDR)
                    begin
                        readMode <= rxByte[0];
                        ackNext <= !addrMatch ? I_IDLE : (rxByte[0] ? I_RDATA : I_REG);
                        state <= addrMatch ? I_ACK : I_IDLE;
                    end
                    else if (state == I_REG)
                    begin
                        counter <= {1'b0, rxByte[5:0]};
                        ackNext <= I_WDATA;
                        state <= I_ACK;
                    end
                    else
                    begin
                        counter <= nextAddr(counter);
                        ackNext <= I_WDATA;
                        state <= I_ACK;
                    end
                end
            end
            if (sclFall && state == I_ACK)
            begin
                if (link.sdaDevOe)
                begin
                    state <= ackNext;
                    if (ackNext == I_RDATA)
                    begin
                        txByte <= {i2cRead[6:0], 1'b0};
                        counter <= nextAddr(counter);
                        link.sdaDevOe <= ~i2cRead[7];
                    end
                    else
                    begin
                        link.sdaDevOe <= 1'b0;
                    end
                end
                else
                begin
                    link.sdaDevOe <= 1'b1;
                end
            end
            if (sclFall && state == I_RDATA)
            begin
                ibit <= 4'(ibit + 4'd1);
                if (ibit == 4'd7)
                begin
                    ibit <= 4'd0;
                    state <= I_MACK;
                    link.sdaDevOe <= 1'b0;
                end
                else
                begin
                    link.sdaDevOe <= ~txByte[7];
                    txByte <= {txByte[6:0], 1'b0};
                end
            end
            if (sclRise && state == I_MACK)
            begin
                state <= link.sda ? I_IDLE : I_ACK;
                ackNext <= I_RDATA;
            end
        end
    end
endmodule : codec_control_port
`default_nettype wire

/* File: hdl/codec_ctrl_if.sv */
// Pins between host and codec control port: 3-wire link and I2C lines.
// Assumes both ends share the clock; I2C lines resolve here as open wires with pull-ups, the 3-wire data pin by a device-first select that idles high.
`timescale 1ns/1ps
`default_nettype none
interface codec_ctrl_if;
    logic chip_select_n;
    logic control_serial_clock;
    logic hostDataOut;
    logic hostDataOe;
    logic devDataOut;
    logic devDataOe;
    logic control_data_io;
    logic sclHostOe;
    logic sdaHostOe;
    logic sdaDevOe;
    logic scl;
    logic sda;
    assign control_data_io = devDataOe ? devDataOut : (hostDataOe ? hostDataOut : 1'b1);
    assign scl = ~sclHostOe;
    assign sda = ~(sdaHostOe | sdaDevOe);
    modport device (
        input chip_select_n, control_serial_clock, control_data_io, scl, sda,
        output devDataOut, devDataOe, sdaDevOe
    );
    modport host (
        input control_data_io, scl, sda,
        output chip_select_n, control_serial_clock, hostDataOut, hostDataOe, sclHostOe, sdaHostOe
    );
endinterface : codec_ctrl_if
`default_nettype wire

/* File: hdl/codec_ctrl_pkg.sv */
// Shared constants for the codec control port: link framing, slave address, register window, timing.
// Assumes one 40 MHz system clock at both ends; link pins are sampled as synchronous inputs.
package codec_ctrl_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int CNT_W = 6;
    localparam int NUM_REGS = 128;
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h09;
    localparam logic [6:0] WRAP_LAST = 7'h4F;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int WIRE3_MAX_HZ = 5000000;
    localparam int I2C_MAX_HZ = 400000;
    // Half periods, shortest times rounded up so the host never exceeds the limits.
    localparam int WIRE3_HALF_CYC = (CLK_HZ + 2 * WIRE3_MAX_HZ - 1) / (2 * WIRE3_MAX_HZ);
    localparam int I2C_HALF_CYC = (CLK_HZ + 2 * I2C_MAX_HZ - 1) / (2 * I2C_MAX_HZ);

    function automatic logic wire3Readable(input logic [6:0] a);
        return (a <= 7'h11) || (a >= 7'h24 && a <= 7'h2B) || (a == 7'h30) || (a == 7'h31);
    endfunction : wire3Readable

    function automatic logic i2cReadable(input logic [6:0] a);
        return wire3Readable(a) && (a != 7'h0D);
    endfunction : i2cReadable

    function automatic logic [6:0] nextAddr(input logic [6:0] a);
        return (a >= WRAP_LAST) ? 7'h00 : 7'(a + 7'h01);
    endfunction : nextAddr
endpackage : codec_ctrl_pkg

/* File: verification/codec_control_port_props.sv */
// Checker for the shared link pins between the host end and the device end.
// Assumes one clock at both ends; instantiated beside the interface, no bind.
`timescale 1ns/1ps
`default_nettype none
module codec_control_port_props (
    input wire logic clock, // System clock.
    input wire logic nrst, // Reset, active low.
    input wire logic chip_select_n, // 3-wire select.
    input wire logic control_serial_clock, // 3-wire clock.
    input wire logic devDataOe, // Device data drive.
    input wire logic devDataOut, // Device data bit.
    input wire logic hostDataOe, // Host data drive.
    input wire logic sdaDevOe, // Device pulls data low.
    input wire logic scl, // Resolved I2C clock.
    input wire logic sda // Resolved I2C data.
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    logic prevSck;
    logic [4:0] riseCount;
    // Rises are counted per frame so the turnaround can be pinned to the eighth clock.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            prevSck <= 1'b1;
            riseCount <= 5'h00;
        end
        else
        begin
            prevSck <= control_serial_clock;
            riseCount <= chip_select_n ? 5'h00 : riseCount + {4'h0, control_serial_clock & ~prevSck};
        end
    end

    sequence s_stop;
        scl && $rose(sda);
    endsequence
    sequence s_start;
        scl && $fell(sda);
    endsequence

    property p_drive_start;
        $rose(devDataOe) |-> riseCount == 5'h08 && !control_serial_clock;
    endproperty
    property p_drive_shift;
        devDataOe && $past(devDataOe) && $changed(devDataOut) |-> !control_serial_clock;
    endproperty
    property p_cs_release;
        chip_select_n [*3] |=> !devDataOe;
    endproperty
    property p_no_drive;
        devDataOe && !chip_select_n |-> riseCount >= 5'h08 && !hostDataOe;
    endproperty
    property p_idle_clock;
        chip_select_n |-> control_serial_clock;
    endproperty
    property p_ack_edge;
        $changed(sdaDevOe) |-> !scl;
    endproperty
    property p_stop_quiet;
        s_stop |=> !sdaDevOe [*8];
    endproperty
    property p_start_free;
        s_start |-> !sdaDevOe;
    endproperty

    a_drive_start: assert property (p_drive_start) else $error("read drive began off the eighth clock fall");
    a_drive_shift: assert property (p_drive_shift) else $error("read data moved while serial clock high");
    a_cs_release: assert property (p_cs_release) else $error("data line held after select rose");
    a_no_drive: assert property (p_no_drive) else $error("data line driven outside read phase");
    a_idle_clock: assert property (p_idle_clock) else $error("serial clock moved outside a frame");
    a_ack_edge: assert property (p_ack_edge) else $error("device data pull changed while clock high");
    a_stop_quiet: assert property (p_stop_quiet) else $error("device drove data after stop");
    a_start_free: assert property (p_start_free) else $error("device held data at start");
endmodule : codec_control_port_props
`default_nettype wire

/* File: verification/test_codec_control_port.sv */
// Self-checking bench: host end and device end joined by the link interface, against a register model.
// Assumes one 40 MHz clock; the model follows the readable address windows of each link.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp); \
        end \
    end
module test_codec_control_port;
    import codec_ctrl_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic pdnLevel = 1'b1;
    logic i2cSel = 1'b0;
    logic addrPin = 1'b1;
    logic addrSel = 1'b1;
    logic [6:0] peekAddr = 7'h00;
    logic [7:0] peekData;
    logic writeStrobe;
    logic [6:0] writeAddr;
    logic useI2c = 1'b0;
    logic start = 1'b0;
    logic hostWrite = 1'b0;
    logic [6:0] regAddr = 7'h00;
    logic [7:0] wrData = 8'h00;
    logic busy;
    logic done;
    logic [7:0] rdData;
    logic nack;
    logic [15:0] lfsrState = 16'hEB47;
    int model [128];
    int strobes = 0;
    int fail_count = 0;
    int tests_run = 0;

    codec_ctrl_if link ();
    codec_control_port codec_control_port_inst (.clock(clock), .nrst(nrst), .power_down_pin(pdnLevel),
        .i2cSelect(i2cSel), .address_select_pin(addrPin), .link(link), .peekAddr(peekAddr),
        .peekData(peekData), .writeStrobe(writeStrobe), .writeAddr(writeAddr));
    codec_control_host codec_control_host_inst (.clock(clock), .nrst(nrst), .useI2c(useI2c),
        .addressSelect(addrSel), .start(start), .write(hostWrite), .regAddr(regAddr), .wrData(wrData),
        .link(link), .busy(busy), .done(done), .rdData(rdData), .nack(nack));
    codec_control_port_props codec_control_port_props_inst (.clock(clock), .nrst(nrst),
        .chip_select_n(link.chip_select_n), .control_serial_clock(link.control_serial_clock),
        .devDataOe(link.devDataOe), .devDataOut(link.devDataOut), .hostDataOe(link.hostDataOe),
        .sdaDevOe(link.sdaDevOe), .scl(link.scl), .sda(link.sda));

    always #12.5 clock = ~clock;
    always @(negedge clock)
        if (writeStrobe === 1'b1)
            strobes++;

    function automatic logic [15:0] nextRand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nextRand

    function automatic logic [7:0] expRead(input logic i2c, input logic [6:0] a);
        logic ok;
        ok = (a <= 7'h11) || (a >= 7'h24 && a <= 7'h2B) || (a == 7'h30) || (a == 7'h31);
        if (i2c && a == 7'h0D)
            ok = 1'b0;
        return ok ? 8'(model[a]) : 8'h00;
    endfunction : expRead

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    task automatic xfer(input logic i2c, input logic wr, input logic [6:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        useI2c <= i2c;
        hostWrite <= wr;
        regAddr <= a;
        wrData <= d;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        @(negedge clock);
        while (done !== 1'b1 && n < 20000)
        begin
            @(negedge clock);
            n++;
        end
        if (n >= 20000)
        begin
            fail_count++;
            finish_test();
        end
        // A 3-wire write lands one edge after done, when the device sees select rise.
        repeat (2) @(negedge clock);
    endtask : xfer

    task automatic peek(input logic [6:0] a);
        @(posedge clock);
        peekAddr <= a;
        @(posedge clock);
        @(negedge clock);
    endtask : peek

    initial
    begin
        logic [6:0] addrs [$];
        logic [7:0] d;
        int s0;
        foreach (model[i])
            model[i] = RESET_VALUE;
        addrs = '{7'h0D, 7'h12, 7'h31, 7'h7F, 7'h00, 7'h2B};
        repeat (2)
        begin
            lfsrState = nextRand(lfsrState);
            addrs.push_back(lfsrState[6:0]);
        end
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        foreach (addrs[i])
        begin
            lfsrState = nextRand(lfsrState);
            d = lfsrState[15:8] | 8'h01;
            xfer(1'b0, 1'b1, addrs[i], d);
            model[addrs[i]] = d;
            `CHECK(writeAddr, addrs[i])
        end
        `CHECK(strobes, addrs.size())
        foreach (addrs[i])
        begin
            xfer(1'b0, 1'b0, addrs[i], 8'h5A);
            `CHECK(rdData, expRead(1'b0, addrs[i]))
            peek(addrs[i]);
            `CHECK(peekData, 8'(model[addrs[i]]))
        end
        $display("3-wire test finished");
        @(posedge clock);
        i2cSel <= 1'b1;
        lfsrState = nextRand(lfsrState);
        d = lfsrState[7:0];
        xfer(1'b1, 1'b1, 7'h24, d);
        model[36] = d;
        `CHECK(nack, 1'b0)
        `CHECK(writeAddr, 7'h24)
        xfer(1'b1, 1'b0, 7'h24, 8'h00);
        `CHECK(rdData, expRead(1'b1, 7'h24))
        xfer(1'b1, 1'b0, 7'h0D, 8'h00);
        `CHECK(rdData, expRead(1'b1, 7'h0D))
        $display("I2C test finished");
        s0 = strobes;
        @(posedge clock);
        addrSel <= 1'b0;
        xfer(1'b1, 1'b1, 7'h24, ~d);
        `CHECK(nack, 1'b1)
        @(posedge clock);
        addrSel <= 1'b1;
        xfer(1'b0, 1'b1, 7'h24, ~d);
        @(posedge clock);
        i2cSel <= 1'b0;
        xfer(1'b1, 1'b1, 7'h24, ~d);
        `CHECK(nack, 1'b1)
        peek(7'h24);
        `CHECK(peekData, 8'(model[36]))
        `CHECK(strobes, s0)
        $display("Refusal test finished");
        @(posedge clock);
        pdnLevel <= 1'b0;
        @(posedge clock);
        pdnLevel <= 1'b1;
        foreach (model[i])
            model[i] = RESET_VALUE;
        for (int i = 0; i < 128; i++)
        begin
            peek(7'(i));
            `CHECK(peekData, 8'(model[i]))
        end
        $display("Power-down test finished");
        finish_test();
    end

    initial
    begin
        #(80000 * 25);
        fail_count++;
        finish_test();
    end
endmodule : test_codec_control_port
`default_nettype wire
